// ### shared/oec_pkg.sv
// Purpose: constants shared by the output enable control block
// Assumes: APB slave with 8-bit byte address and 32-bit data
// Notes:   enable flags sit in bit 0 of their own word
`default_nettype none
package oec_pkg;

  // register byte offsets
  localparam logic [7:0] OEC_REC1_OFS = 8'h00;
  localparam logic [7:0] OEC_REC2_OFS = 8'h04;
  localparam logic [7:0] OEC_REF_OFS  = 8'h08;
  localparam logic [7:0] OEC_TRIG_OFS = 8'h0C;
  localparam logic [7:0] OEC_STAT_OFS = 8'h10;
  localparam logic [7:0] OEC_MASK_OFS = 8'h14;
  localparam logic [7:0] OEC_ERR_OFS  = 8'h18;
  localparam logic [7:0] OEC_SENS_OFS = 8'h1C;

  // enable flags: record 1, record 2, reference source, trigger
  localparam int         OEC_NUM_EN   = 4;
  localparam int         OEC_EN_REC1  = 0;
  localparam int         OEC_EN_REC2  = 1;
  localparam int         OEC_EN_REF   = 2;
  localparam int         OEC_EN_TRIG  = 3;
  localparam logic [7:0] OEC_EN_OFS [OEC_NUM_EN] = '{
    OEC_REC1_OFS, OEC_REC2_OFS, OEC_REF_OFS, OEC_TRIG_OFS};
  localparam int         OEC_EN_BIT   = 0;
  localparam logic       OEC_EN_RST   = 1'b0;

  // status and mask fields
  localparam int         OEC_ST_W        = 2;
  localparam int         OEC_ST_CONFLICT = 0;
  localparam int         OEC_ST_TRIG     = 1;
  localparam logic [1:0] OEC_ST_RST      = 2'h0;
  localparam logic [1:0] OEC_MASK_RST    = 2'h0;

  // settings conflict code, -221 as 32-bit two's complement
  localparam logic [31:0] OEC_ERR_CONFLICT = 32'hFFFFFF23;
  localparam logic [31:0] OEC_ERR_NONE     = 32'h00000000;

  // sensing pin bit positions in the synchroniser bus
  localparam int OEC_SN_W       = 4;
  localparam int OEC_SN_TMODE   = 0;
  localparam int OEC_SN_SETTLED = 1;
  localparam int OEC_SN_AVGONLY = 2;
  localparam int OEC_SN_EXTSRC  = 3;

endpackage
`default_nettype wire

// ### src/oec_sync.sv
// Purpose: two-flop synchroniser for a bus of independent levels
// Assumes: each bit is a slow level; no word coherence is needed
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module oec_sync #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  // levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] stage1;

  // one pair of flops per bit
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        stage1[i] <= 1'b0;
        dout[i]   <= 1'b0;
      end else begin
        stage1[i] <= din[i];
        dout[i]   <= stage1[i];
      end
    end
  end

endmodule
`default_nettype wire

// ### src/oec_output_enable.sv
// Purpose: enable flags for record, reference and trigger outputs
// Assumes: APB master per protocol; sensing pins are asynchronous
// Notes:   each transfer has one wait state; registers are word wide
//
// What this block does
// - two record outputs each have an enable flag set by a write.
// - reset clears both record output enables.
// - reading a record enable returns 1 when on, 0 when off.
// - reference source output has one enable flag set by a write.
// - reset clears the reference source enable.
// - reading the reference enable returns 1 when on, 0 when off.
// - trigger output has one enable flag set by a write.
// - in triggered average mode trigger asserts only once settled.
// - reset clears the trigger output enable.
// - reading the trigger enable returns 1 when on, 0 when off.
// - trigger with average-only sensor, non-external source flags -221.
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module oec_output_enable
  import oec_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  // sensing subsystem pins
  input  wire logic        trig_avg_mode,
  input  wire logic        meas_settled,
  input  wire logic        avg_only_sensor,
  input  wire logic        trig_src_external,
  // auxiliary output controls
  output logic             rec1_en,
  output logic             rec2_en,
  output logic             reference_source_en,
  output logic             trig_out,
  // interrupt
  output logic             irq
);

  logic [OEC_NUM_EN-1:0] en_flag;
  logic [OEC_SN_W-1:0]   sense;
  logic [OEC_ST_W-1:0]   status;
  logic [OEC_ST_W-1:0]   next_status;
  logic [OEC_ST_W-1:0]   mask;
  logic [OEC_ST_W-1:0]   events;
  logic [OEC_ST_W-1:0]   st_clear;
  logic [31:0]           next_rdata;
  logic                  next_err;
  logic                  access;
  logic                  wr_fire;
  logic                  wr_lane0;
  logic                  conflict_now;
  logic                  conflict_q;
  logic                  next_trig;
  logic                  trig_q;
  logic                  first_cyc;

  // sensing pins cross into the mclk domain
  oec_sync #(
    .W (OEC_SN_W)
  ) u_sync (
    .mclk (mclk),
    .rstn (rstn),
    .din  ({trig_src_external, avg_only_sensor,
            meas_settled, trig_avg_mode}),
    .dout (sense)
  );

  // bus phases: first access cycle, then the completing one
  assign access   = psel && penable && !pready;
  assign wr_fire  = psel && penable && pready && pwrite;
  assign wr_lane0 = wr_fire && pstrb[0];

  // one wait state per transfer
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
    end else begin
      pready <= access;
    end
  end

  // enable flags, one per auxiliary output
  for (genvar i = 0; i < OEC_NUM_EN; i++) begin : g_en
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        en_flag[i] <= OEC_EN_RST;
      end else if (wr_lane0 && paddr == OEC_EN_OFS[i]) begin
        en_flag[i] <= pwdata[OEC_EN_BIT];
      end
    end
  end

  // record and reference flags drive their output controls directly
  assign rec1_en             = en_flag[OEC_EN_REC1];
  assign rec2_en             = en_flag[OEC_EN_REC2];
  assign reference_source_en = en_flag[OEC_EN_REF];

  // trigger held back in triggered average mode until settled
  assign next_trig = en_flag[OEC_EN_TRIG] &&
                     (!sense[OEC_SN_TMODE] ||
                      sense[OEC_SN_SETTLED]);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= next_trig;
    end
  end

  assign trig_out = trig_q;

  // trigger use with an average-only sensor and internal source
  assign conflict_now = en_flag[OEC_EN_TRIG] &&
                        sense[OEC_SN_AVGONLY] &&
                        !sense[OEC_SN_EXTSRC];

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      conflict_q <= 1'b0;
    end else begin
      conflict_q <= conflict_now;
    end
  end

  // events: conflict begins, trigger output rises
  always_comb begin
    events                  = '0;
    events[OEC_ST_CONFLICT] = conflict_now && !conflict_q;
    events[OEC_ST_TRIG]     = next_trig && !trig_q;
  end

  // sticky status, write one to clear, a new event wins
  always_comb begin
    st_clear = '0;
    if (wr_lane0 && paddr == OEC_STAT_OFS) begin
      st_clear = pwdata[OEC_ST_W-1:0];
    end
    next_status = (status & ~st_clear) | events;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      status <= OEC_ST_RST;
    end else begin
      status <= next_status;
    end
  end

  // interrupt mask
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mask <= OEC_MASK_RST;
    end else if (wr_lane0 && paddr == OEC_MASK_OFS) begin
      mask <= pwdata[OEC_ST_W-1:0];
    end
  end

  // level interrupt while an unmasked status bit is set
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status & mask);
    end
  end

  // read decode, unmapped addresses answer with an error
  always_comb begin
    next_rdata = '0;
    next_err   = 1'b0;
    case (paddr)
      OEC_REC1_OFS: begin
        next_rdata[OEC_EN_BIT] = en_flag[OEC_EN_REC1];
      end
      OEC_REC2_OFS: begin
        next_rdata[OEC_EN_BIT] = en_flag[OEC_EN_REC2];
      end
      OEC_REF_OFS: begin
        next_rdata[OEC_EN_BIT] = en_flag[OEC_EN_REF];
      end
      OEC_TRIG_OFS: begin
        next_rdata[OEC_EN_BIT] = en_flag[OEC_EN_TRIG];
      end
      OEC_STAT_OFS: begin
        next_rdata[OEC_ST_W-1:0] = status;
      end
      OEC_MASK_OFS: begin
        next_rdata[OEC_ST_W-1:0] = mask;
      end
      OEC_ERR_OFS: begin
        next_rdata = status[OEC_ST_CONFLICT] ?
                     OEC_ERR_CONFLICT : OEC_ERR_NONE;
      end
      OEC_SENS_OFS: begin
        next_rdata[OEC_SN_W:0] = {sense, conflict_now};
      end
      default: begin
        next_err = 1'b1;
      end
    endcase
  end

  // read data and error captured in the wait state
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (access) begin
      prdata  <= pwrite ? '0 : next_rdata;
      pslverr <= next_err;
    end else begin
      pslverr <= 1'b0;
    end
  end

  // marks the first cycle after reset release, for checks only
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      first_cyc <= 1'b1;
    end else begin
      first_cyc <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  // record enable follows the written bit
  a_rec_write_sets: assert property (
    (wr_lane0 && paddr == OEC_REC2_OFS)
    |=> (rec2_en == $past(pwdata[OEC_EN_BIT]))
  ) else $error("record 2 enable did not take written value");

  // record outputs off after reset
  a_rec_reset_off: assert property (
    first_cyc |-> (!rec1_en && !rec2_en)
  ) else $error("record enable set after reset");

  // record enable read back as 1 or 0
  a_rec_read_back: assert property (
    (psel && penable && pready && !pwrite && paddr == OEC_REC1_OFS)
    |-> (prdata == {31'h0, rec1_en} && !pslverr)
  ) else $error("record 1 read value wrong");

  // reference enable follows the written bit
  a_ref_write_sets: assert property (
    (wr_lane0 && paddr == OEC_REF_OFS)
    |=> (reference_source_en == $past(pwdata[OEC_EN_BIT]))
  ) else $error("reference enable did not take written value");

  // reference output off after reset
  a_ref_reset_off: assert property (
    first_cyc |-> !reference_source_en
  ) else $error("reference enable set after reset");

  // reference enable read back
  a_ref_read_back: assert property (
    (psel && penable && pready && !pwrite && paddr == OEC_REF_OFS)
    |-> (prdata == {31'h0, reference_source_en})
  ) else $error("reference read value wrong");

  // trigger enable follows the written bit
  a_trig_write_sets: assert property (
    (wr_lane0 && paddr == OEC_TRIG_OFS)
    |=> (en_flag[OEC_EN_TRIG] == $past(pwdata[OEC_EN_BIT]))
  ) else $error("trigger enable did not take written value");

  // no trigger before settling in triggered average mode
  a_trig_wait_settle: assert property (
    (trig_out && $past(sense[OEC_SN_TMODE]))
    |-> ($past(sense[OEC_SN_SETTLED]) && $past(en_flag[OEC_EN_TRIG]))
  ) else $error("trigger asserted before measurement settled");

  // trigger off after reset
  a_trig_reset_off: assert property (
    first_cyc |-> (!trig_out && !en_flag[OEC_EN_TRIG])
  ) else $error("trigger enabled after reset");

  // trigger enable read back
  a_trig_read_back: assert property (
    (psel && penable && pready && !pwrite && paddr == OEC_TRIG_OFS)
    |-> (prdata == {31'h0, en_flag[OEC_EN_TRIG]})
  ) else $error("trigger read value wrong");

  // conflict start latches the conflict flag in status; the error code is not checked
  a_conflict_flag: assert property (
    (conflict_now && !conflict_q)
    |=> status[OEC_ST_CONFLICT] ##1
        (!psel || status[OEC_ST_CONFLICT] ||
         $past(wr_lane0 && paddr == OEC_STAT_OFS))
  ) else $error("settings conflict not flagged");

  // record 1 flag stands still without a write to it
  a_flag_holds: assert property (
    !(wr_lane0 && paddr == OEC_REC1_OFS) |=> $stable(rec1_en)
  ) else $error("record 1 enable changed without a write");

endmodule
`default_nettype wire

// ### verif/oec_host.sv
// Purpose: apb host model issuing enable commands and queries
// Assumes: slave raises pready for one cycle to end each access
// Notes:   released address and data show inverted last values
`timescale 1ns/1ps
`default_nettype none
module oec_host (
  // clock
  input  wire logic        mclk,
  // apb request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb,
  // apb answer
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
  end

  // one transfer, held until pready is seen high; bench timeout ends a hang
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ### verif/tb_output_enable_control.sv
// Purpose: self-checking bench for the output enable block
// Assumes: host model issues apb transfers; bench drives sense pins
// Notes:   sense pins change only at rising edges
`timescale 1ns/1ps
`default_nettype none
module tb_output_enable_control;
  import oec_pkg::*;
  // clock, reset, sense pins
  logic mclk, rstn, tmode, settled, avgonly, extsrc;
  // apb wires
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  // outputs
  logic rec1_en, rec2_en, reference_source_en, trig_out, irq;
  wire logic [3:0] pins = {trig_out, reference_source_en, rec2_en, rec1_en};
  int num_errors, samples_checked, cycles;
  logic [31:0] rd;
  logic err;

  oec_output_enable oec_output_enable_i (.mclk(mclk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .trig_avg_mode(tmode), .meas_settled(settled),
    .avg_only_sensor(avgonly), .trig_src_external(extsrc),
    .rec1_en(rec1_en), .rec2_en(rec2_en),
    .reference_source_en(reference_source_en), .trig_out(trig_out),
    .irq(irq));
  oec_host oec_host_i (.mclk(mclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr));

  // clock
  always #20 mclk = ~mclk;

  // hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask

  // register write, full strobes
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    oec_host_i.xfer(1'b1, a, d, 4'hF, rd, err);
  endtask

  // register read compared with expected word
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    oec_host_i.xfer(1'b0, a, 32'h00000000, 4'h0, rd, err);
    chk(rd, exp);
    chk(err, 1'b0);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // verdict
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    tmode = 1'b0;
    settled = 1'b0;
    avgonly = 1'b0;
    extsrc = 1'b0;
    cyc(2);
    rstn <= 1'b1;
    chk(pins, 4'h0);
    for (int i = 0; i < OEC_NUM_EN; i++) begin
      rc(OEC_EN_OFS[i], 32'h00000000);
      wr(OEC_EN_OFS[i], 32'h00000001);
      cyc(2);
      chk(pins, 4'h1 << i);
      rc(OEC_EN_OFS[i], 32'h00000001);
      rc(OEC_EN_OFS[i], 32'h00000001);
      oec_host_i.xfer(1'b1, OEC_EN_OFS[i], 32'h0, 4'h0, rd, err);
      rc(OEC_EN_OFS[i], 32'h00000001);
      wr(OEC_EN_OFS[i], 32'h00000000);
      rc(OEC_EN_OFS[i], 32'h00000000);
    end
    oec_host_i.xfer(1'b0, 8'h20, 32'h0, 4'h0, rd, err);
    chk(err, 1'b1);
    // triggered average mode: trigger waits for settling
    tmode <= 1'b1;
    cyc(4);
    wr(OEC_STAT_OFS, 32'h00000003);
    wr(OEC_TRIG_OFS, 32'h00000001);
    cyc(6);
    chk(trig_out, 1'b0);
    rc(OEC_STAT_OFS, 32'h00000000);
    settled <= 1'b1;
    cyc(4);
    chk(trig_out, 1'b1);
    rc(OEC_STAT_OFS, 32'h00000002);
    chk(irq, 1'b0);
    wr(OEC_MASK_OFS, 32'h00000003);
    rc(OEC_MASK_OFS, 32'h00000003);
    cyc(2);
    chk(irq, 1'b1);
    wr(OEC_STAT_OFS, 32'h00000002);
    cyc(2);
    chk(irq, 1'b0);
    // average-only sensor with internal source conflicts
    avgonly <= 1'b1;
    cyc(5);
    rc(OEC_STAT_OFS, 32'h00000001);
    rc(OEC_ERR_OFS, OEC_ERR_CONFLICT);
    rc(OEC_SENS_OFS, 32'h0000000F);
    chk(irq, 1'b1);
    extsrc <= 1'b1;
    cyc(5);
    wr(OEC_STAT_OFS, 32'h00000001);
    rc(OEC_ERR_OFS, OEC_ERR_NONE);
    cyc(2);
    chk(irq, 1'b0);
    // reset in mid-run clears every enable
    for (int i = 0; i < OEC_NUM_EN; i++) begin
      wr(OEC_EN_OFS[i], 32'h00000001);
    end
    rstn <= 1'b0;
    cyc(2);
    rstn <= 1'b1;
    cyc(1);
    chk(pins, 4'h0);
    for (int i = 0; i < OEC_NUM_EN; i++) begin
      rc(OEC_EN_OFS[i], 32'h00000000);
    end
    rc(OEC_STAT_OFS, 32'h00000000);
    rc(OEC_MASK_OFS, 32'h00000000);
    chk(irq, 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
